//--- hw/hcb_regs.svh
// hcb_regs.svh: command codes, field positions, reset values, timing
// assumes: included by bare name from the package and the design modules
`ifndef HCB_REGS_SVH
`define HCB_REGS_SVH

// command codes, bit 7 set marks a write
`define HCB_WR_BIT        7
`define HCB_CMD_ISO_SIZE  8'h30
`define HCB_CMD_WIN_SETUP 8'h32
`define HCB_CMD_ISO_A     8'h40
`define HCB_CMD_ISO_B     8'h42
`define HCB_CMD_WIN_DATA  8'h45
`define HCB_CMD_SWITCH    8'h47
`define HCB_CMD_BUF_STATE 8'h2C
`define HCB_CMD_XFER_CNT  8'h22
`define HCB_CMD_IRQ_STAT  8'h24
`define HCB_CMD_IRQ_MASK  8'h25

// direct window setup fields
`define HCB_WIN_CNT_LSB   16
`define HCB_WIN_ADDR_MSB  14
`define HCB_WIN_RESET     32'h00000000
`define HCB_SIZE_RESET    16'h0000
`define HCB_RATE_W        4

// buffer state bits
`define HCB_BS_FULL_A     0
`define HCB_BS_ACT_A      5
`define HCB_BS_DONE_A     8

// processor interrupt bits
`define HCB_IRQ_EOT       0

// timing
`define HCB_CLK_NS        100
`define HCB_MS_NS         1000000
`define HCB_MS_CYCLES     (`HCB_MS_NS / `HCB_CLK_NS)
`define HCB_WORD_BYTES    16'h0002

// host software register indices
`define HCB_H_CMD         3'h0
`define HCB_H_WDATA       3'h1
`define HCB_H_RDREQ       3'h2
`define HCB_H_RXDATA      3'h3
`define HCB_H_STATUS      3'h4
`define HCB_H_MASK        3'h5

`endif

//--- hw/hcb_pkg.sv
// hcb_pkg: types used by the device end and the bench of the buffer access link
// assumes: hcb_regs.svh on the include path
`include "hcb_regs.svh"
package hcb_pkg;
	typedef logic [7:0]  hcb_cmd_t;
	typedef logic [15:0] hcb_word_t;

	// device command tracking, one-hot
	typedef enum logic [2:0] {
		HCB_IDLE   = 3'b001,
		HCB_REG    = 3'b010,
		HCB_STREAM = 3'b100
	} hcb_state_e;
endpackage

//--- hw/hcb_if.sv
// hcb_if: parallel command/data link between processor end and device end
// assumes: one clock shared by both ends; the bench instantiates it
`timescale 1ns/100ps
interface hcb_if;
	logic      cmd_stb;
	logic [7:0]  cmd;
	logic      wr_stb;
	logic      rd_stb;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic      irq;

	modport dev  (input cmd_stb, cmd, wr_stb, rd_stb, wdata, output rdata, irq);
	modport host (output cmd_stb, cmd, wr_stb, rd_stb, wdata, input rdata, irq);
endinterface

//--- hw/hcb_dev.sv
// hcb_dev: device end, buffer memory with window and iso streaming ports
// assumes: host issues one strobe per cycle; read data valid next cycle
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "hcb_regs.svh"

// Operation
// - setup register holds count, start address
// - setup register commands 32h read, B2h write
// - window reaches any iso, interrupt, async location
// - window data port, commands 45h and C5h
// - processor programs setup before window data
// - one iso size sets both buffers
// - iso size commands 30h read, B0h write
// - buffer a port, 40h/C0h, one word
// - buffer a port always starts at zero
// - buffer b port, 42h/C2h, one word
// - buffer b port always starts at the iso size
// - processor loads counter, checks state first
// - port pointer advances with every access
// - count reached sets end flag, state
// - four-bit switch interval, 0 to 15 ms
// - switch interval commands 47h and C7h
// - per-buffer done flag after controller read
module hcb_dev
	import hcb_pkg::*;
#(
	parameter int MEM_WORDS  = 256,
	parameter int CYC_PER_MS = `HCB_MS_CYCLES
) (
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic resetn_i,
	// link to the processor end
	hcb_if.dev        link,
	// user side
	output logic      iso_b_active_o,
	output logic      eot_pend_o
);
	localparam int AW = $clog2(MEM_WORDS);
	localparam int MW = $clog2(CYC_PER_MS + 1);

	hcb_state_e  state_q;
	logic [7:0]  cmd_q;
	logic        half_q;
	logic [15:0] ptr_q;
	logic [15:0] iso_size_q;
	logic [15:0] window_byte_count_q;
	logic [14:0] window_start_addr_q;
	logic [3:0]  switch_interval_ms_q;
	logic [15:0] xfer_cnt_q;
	logic [1:0]  full_q;
	logic [1:0]  done_q;
	logic [2:0]  list_ctl_q;
	logic        iso_b_act_q;
	logic        irq_stat_q;
	logic        irq_mask_q;
	logic        irq_q;
	logic [15:0] rdata_q;
	logic [15:0] mem_q [MEM_WORDS];
	logic [MW-1:0] ms_cnt_q;
	logic [3:0]  ivl_cnt_q;

	logic [7:0]  base;
	logic        is_wr;
	logic        access;
	logic [15:0] byte_addr;
	logic [15:0] limit;
	logic        eot_hit;
	logic        ms_tick;
	logic        toggle;
	logic        irq_clr;
	logic [31:0] setup_word;

	//--------------------------------------------------------------
	// command decode and addressing
	//--------------------------------------------------------------
	assign base       = {1'b0, cmd_q[6:0]};
	assign is_wr      = cmd_q[`HCB_WR_BIT];
	assign access     = (state_q == HCB_STREAM) && (link.wr_stb || link.rd_stb);
	assign setup_word = {window_byte_count_q, 1'b0, window_start_addr_q};

	// fixed-start ports add the running pointer to zero (a) or the iso size (b), no random offset
	always_comb begin
		byte_addr = ptr_q;
		limit     = xfer_cnt_q;
		if (base == `HCB_CMD_ISO_B) begin
			byte_addr = iso_size_q + ptr_q;
		end else if (base == `HCB_CMD_WIN_DATA) begin
			byte_addr = {1'b0, window_start_addr_q} + ptr_q;
			limit     = window_byte_count_q;
		end
	end

	// last word reached once pointer plus one word covers the count
	assign eot_hit = access && ((ptr_q + `HCB_WORD_BYTES) >= limit);

	//--------------------------------------------------------------
	// command tracking
	//--------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			state_q <= HCB_IDLE;
			cmd_q   <= 8'h00;
			half_q  <= 1'b0;
			ptr_q   <= 16'h0000;
		end else if (link.cmd_stb) begin
			cmd_q  <= link.cmd;
			half_q <= 1'b0;
			ptr_q  <= 16'h0000;
			case ({1'b0, link.cmd[6:0]})
				`HCB_CMD_ISO_A,
				`HCB_CMD_ISO_B,
				`HCB_CMD_WIN_DATA: state_q <= HCB_STREAM;
				default:           state_q <= HCB_REG;
			endcase
		end else if (access) begin
			ptr_q <= ptr_q + `HCB_WORD_BYTES;
			if (eot_hit) begin
				state_q <= HCB_IDLE;
			end
		end else if ((state_q == HCB_REG) && (link.wr_stb || link.rd_stb)) begin
			half_q <= ~half_q;                                        // low word then high
		end
	end

	//--------------------------------------------------------------
	// register writes
	//--------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			iso_size_q           <= `HCB_SIZE_RESET;
			window_byte_count_q  <= 16'(`HCB_WIN_RESET >> `HCB_WIN_CNT_LSB);
			window_start_addr_q  <= 15'h0000;
			switch_interval_ms_q <= 4'h0;
			xfer_cnt_q           <= 16'h0000;
			list_ctl_q           <= 3'h0;
			irq_mask_q           <= 1'b0;
		end else if ((state_q == HCB_REG) && link.wr_stb && is_wr) begin
			case (base)
				`HCB_CMD_ISO_SIZE: iso_size_q <= link.wdata;
				`HCB_CMD_WIN_SETUP: begin
					if (half_q) begin
						window_byte_count_q <= link.wdata;
					end else begin
						window_start_addr_q <= link.wdata[`HCB_WIN_ADDR_MSB:0];
					end
				end
				`HCB_CMD_SWITCH:    switch_interval_ms_q <= link.wdata[3:0];
				`HCB_CMD_XFER_CNT:  xfer_cnt_q <= link.wdata;
				`HCB_CMD_BUF_STATE: list_ctl_q <= link.wdata[4:2];
				`HCB_CMD_IRQ_MASK:  irq_mask_q <= link.wdata[`HCB_IRQ_EOT];
				default: ;
			endcase
		end
	end

	//--------------------------------------------------------------
	// buffer memory, read data registered for next-cycle answer
	//--------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (access && link.wr_stb && is_wr) begin
			mem_q[byte_addr[AW:1]] <= link.wdata;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rdata_q <= 16'h0000;
		end else if (access && link.rd_stb) begin
			rdata_q <= mem_q[byte_addr[AW:1]];
		end else if ((state_q == HCB_REG) && link.rd_stb) begin
			case (base)
				`HCB_CMD_ISO_SIZE:  rdata_q <= iso_size_q;
				`HCB_CMD_WIN_SETUP: rdata_q <= half_q ? setup_word[31:16]
				                                      : setup_word[15:0];
				`HCB_CMD_SWITCH:    rdata_q <= {12'h000, switch_interval_ms_q};
				`HCB_CMD_XFER_CNT:  rdata_q <= xfer_cnt_q;
				`HCB_CMD_BUF_STATE: rdata_q <= {6'h00, done_q, 1'b0, iso_b_act_q,
				                                ~iso_b_act_q, list_ctl_q, full_q};
				`HCB_CMD_IRQ_STAT:  rdata_q <= {15'h0000, irq_stat_q};
				`HCB_CMD_IRQ_MASK:  rdata_q <= {15'h0000, irq_mask_q};
				default:            rdata_q <= 16'h0000;
			endcase
		end
	end

	//--------------------------------------------------------------
	// switch timer; interval zero leaves the active buffer alone
	//--------------------------------------------------------------
	assign ms_tick = (ms_cnt_q == MW'(CYC_PER_MS - 1));
	assign toggle  = ms_tick && (switch_interval_ms_q != 4'h0)
	                 && ((ivl_cnt_q + 4'h1) >= switch_interval_ms_q);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ms_cnt_q    <= '0;
			ivl_cnt_q   <= 4'h0;
			iso_b_act_q <= 1'b0;
		end else begin
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + MW'(1);
			if (toggle) begin
				ivl_cnt_q   <= 4'h0;
				iso_b_act_q <= ~iso_b_act_q;
			end else if (switch_interval_ms_q == 4'h0) begin
				// parked at zero, else a stale tally skews the first interval
				ivl_cnt_q <= 4'h0;
			end else if (ms_tick) begin
				ivl_cnt_q <= ivl_cnt_q + 4'h1;
			end
		end
	end

	//--------------------------------------------------------------
	// buffer state: leaving buffer counts as read by the controller
	//--------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			full_q <= 2'b00;
			done_q <= 2'b00;
		end else begin
			if (eot_hit && is_wr && (base != `HCB_CMD_WIN_DATA)) begin
				full_q[base == `HCB_CMD_ISO_B] <= 1'b1;
				done_q[base == `HCB_CMD_ISO_B] <= 1'b0;
			end
			// controller finishing wins over a refill ending this cycle
			if (toggle) begin
				full_q[iso_b_act_q] <= 1'b0;
				done_q[iso_b_act_q] <= 1'b1;
			end
		end
	end

	//--------------------------------------------------------------
	// interrupt: sticky end flag, cleared by reading it, set wins
	//--------------------------------------------------------------
	assign irq_clr = (state_q == HCB_REG) && link.rd_stb && (base == `HCB_CMD_IRQ_STAT);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			irq_stat_q <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			irq_stat_q <= eot_hit || (irq_stat_q && !irq_clr);
			irq_q      <= (eot_hit || (irq_stat_q && !irq_clr)) && irq_mask_q;
		end
	end

	assign link.rdata     = rdata_q;
	assign link.irq       = irq_q;
	assign iso_b_active_o = iso_b_act_q;
	assign eot_pend_o     = irq_stat_q;
endmodule

//--- hw/hcb_host.sv
// hcb_host: processor end, turns software register writes into link cycles
// assumes: software follows the setup-then-data order on its own
`timescale 1ns/100ps
`include "hcb_regs.svh"
module hcb_host
	import hcb_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// software register port
	input  wire logic [2:0]  sw_addr_i,
	input  wire logic [15:0] sw_wdata_i,
	input  wire logic        sw_wr_i,
	input  wire logic        sw_rd_i,
	output logic      [15:0] sw_rdata_o,
	output logic             irq_o,
	// link to the device end
	hcb_if.host              link
);
	logic        cmd_stb_q;
	logic [7:0]  cmd_q;
	logic        wr_stb_q;
	logic        rd_stb_q;
	logic [15:0] wdata_q;
	logic        rx_wait_q;
	logic [15:0] rx_q;
	logic [1:0]  stat_q;
	logic [1:0]  mask_q;
	logic [1:0]  ev;
	logic [1:0]  stat_d;
	logic        dev_irq_q;
	logic [15:0] sw_rdata_q;
	logic        irq_q;

	//--------------------------------------------------------------
	// link strobes, one cycle each, straight from software writes
	//--------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			cmd_stb_q <= 1'b0;
			wr_stb_q  <= 1'b0;
			rd_stb_q  <= 1'b0;
			cmd_q     <= 8'h00;
			wdata_q   <= 16'h0000;
		end else begin
			cmd_stb_q <= sw_wr_i && (sw_addr_i == `HCB_H_CMD);
			wr_stb_q  <= sw_wr_i && (sw_addr_i == `HCB_H_WDATA);
			rd_stb_q  <= sw_wr_i && (sw_addr_i == `HCB_H_RDREQ);
			if (sw_wr_i && (sw_addr_i == `HCB_H_CMD)) begin
				cmd_q <= sw_wdata_i[7:0];
			end
			if (sw_wr_i && (sw_addr_i == `HCB_H_WDATA)) begin
				wdata_q <= sw_wdata_i;
			end
		end
	end

	//--------------------------------------------------------------
	// read capture: device answers the cycle after rd_stb
	//--------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rx_wait_q <= 1'b0;
			rx_q      <= 16'h0000;
		end else begin
			rx_wait_q <= rd_stb_q;
			if (rx_wait_q) begin
				rx_q <= link.rdata;
			end
		end
	end

	//--------------------------------------------------------------
	// events: read data landed, device interrupt rose; read clears
	//--------------------------------------------------------------
	assign ev     = {link.irq && !dev_irq_q, rx_wait_q};
	assign stat_d = ev | ((sw_rd_i && (sw_addr_i == `HCB_H_STATUS)) ? 2'b00 : stat_q);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dev_irq_q <= 1'b0;
			stat_q    <= 2'b00;
			mask_q    <= 2'b00;
			irq_q     <= 1'b0;
		end else begin
			dev_irq_q <= link.irq;
			stat_q    <= stat_d;
			irq_q     <= |(stat_d & mask_q);
			if (sw_wr_i && (sw_addr_i == `HCB_H_MASK)) begin
				mask_q <= sw_wdata_i[1:0];
			end
		end
	end

	// software read data, valid the cycle after sw_rd_i
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			sw_rdata_q <= 16'h0000;
		end else if (sw_rd_i) begin
			case (sw_addr_i)
				`HCB_H_CMD:    sw_rdata_q <= {8'h00, cmd_q};
				`HCB_H_WDATA:  sw_rdata_q <= wdata_q;
				`HCB_H_RXDATA: sw_rdata_q <= rx_q;
				`HCB_H_STATUS: sw_rdata_q <= {13'h0000, dev_irq_q, stat_q};
				`HCB_H_MASK:   sw_rdata_q <= {14'h0000, mask_q};
				default:       sw_rdata_q <= 16'h0000;
			endcase
		end
	end

	assign link.cmd_stb = cmd_stb_q;
	assign link.cmd     = cmd_q;
	assign link.wr_stb  = wr_stb_q;
	assign link.rd_stb  = rd_stb_q;
	assign link.wdata   = wdata_q;
	assign sw_rdata_o   = sw_rdata_q;
	assign irq_o        = irq_q;
endmodule

//--- verif/hcb_link_asserts.sv
// hcb_link_asserts: concurrent checks on the processor/device link
// assumes: instantiated once in the bench beside the link interface
`timescale 1ns/100ps
module hcb_link_asserts (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// link signals
	input  wire logic        cmd_stb,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	input  wire logic [15:0] rdata,
	input  wire logic        irq
);
	logic seen_rd_q;
	logic seen_stb_q;

	// ----------------------------------------
	// first traffic since reset
	// ----------------------------------------
	// sticky, so checks on idle values stop once traffic starts
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			seen_rd_q  <= 1'b0;
			seen_stb_q <= 1'b0;
		end else begin
			seen_rd_q  <= seen_rd_q | rd_stb;
			seen_stb_q <= seen_stb_q | cmd_stb | wr_stb | rd_stb;
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	strobe_onehot_a: assert property ($onehot0({cmd_stb, wr_stb, rd_stb}))
		else $error("link strobes overlap");
	reset_quiet_a: assert property (disable iff (1'b0)
		!resetn_i |=> !irq && !cmd_stb && !wr_stb && !rd_stb && rdata == 16'h0000)
		else $error("link not quiet after reset");
	rdata_hold_a: assert property (!$past(rd_stb) && $past(resetn_i) |-> $stable(rdata))
		else $error("read word moved without a read");
	rdata_reset_a: assert property (!seen_rd_q |-> rdata == 16'h0000)
		else $error("read word not zero before first read");
	irq_rise_a: assert property ($rose(irq) |->
		$past(wr_stb || rd_stb) || $past(wr_stb || rd_stb, 2))
		else $error("irq rose without a data word");
	irq_fall_a: assert property ($fell(irq) |->
		$past(wr_stb || rd_stb) || $past(wr_stb || rd_stb, 2))
		else $error("irq fell without a clearing access");
	irq_steady_a: assert property ((!cmd_stb && !wr_stb && !rd_stb) [*2] |=> $stable(irq))
		else $error("irq moved on an idle link");
	irq_idle_a: assert property (!seen_stb_q |-> !irq)
		else $error("irq high before any traffic");

	// main scenarios
	cover property ($rose(irq));
	cover property (rd_stb ##1 $changed(rdata));
	cover property (cmd_stb ##2 wr_stb);
endmodule

//--- verif/hc_buffer_access_ports_bench.sv
// hc_buffer_access_ports_bench: both link ends joined, driven from the software port
// assumes: device built with 10 cycles a millisecond to keep switch tests short
`timescale 1ns/100ps
module hc_buffer_access_ports_bench
	import hcb_pkg::*;
;
	typedef struct {
		hcb_cmd_t  cmd;
		hcb_word_t wval;
		hcb_word_t exp;
	} hcb_row_s;

	logic       mclk;
	logic       resetn;
	logic [2:0] sw_addr;
	hcb_word_t  sw_wdata;
	logic       sw_wr;
	logic       sw_rd;
	hcb_word_t  sw_rdata;
	logic       irq;
	logic       iso_b_act;
	logic       eot_pend;
	int         fail_count;
	int         cmp_count;
	int         n;
	hcb_word_t  got;
	hcb_row_s   rows [7];

	// ----------------------------------------
	// design ends and checker
	// ----------------------------------------
	hcb_if link_if ();
	hcb_host hcb_host_inst (.mclk_i(mclk), .resetn_i(resetn), .sw_addr_i(sw_addr),
		.sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd),
		.sw_rdata_o(sw_rdata), .irq_o(irq), .link(link_if));
	hcb_dev #(.CYC_PER_MS(10)) hcb_dev_inst (.mclk_i(mclk), .resetn_i(resetn),
		.link(link_if), .iso_b_active_o(iso_b_act), .eot_pend_o(eot_pend));
	hcb_link_asserts hcb_link_asserts_inst (.mclk_i(mclk), .resetn_i(resetn),
		.cmd_stb(link_if.cmd_stb), .wr_stb(link_if.wr_stb), .rd_stb(link_if.rd_stb),
		.rdata(link_if.rdata), .irq(link_if.irq));

	// 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// one-cycle strobes, so a gap cycle always separates two accesses
	task automatic sw_w(input logic [2:0] a, input hcb_word_t d);
		@(posedge mclk);
		sw_addr  <= a;
		sw_wdata <= d;
		sw_wr    <= 1'b1;
		@(posedge mclk);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_r(input logic [2:0] a, output hcb_word_t d);
		@(posedge mclk);
		sw_addr <= a;
		sw_rd   <= 1'b1;
		@(posedge mclk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic lc(input hcb_cmd_t c);
		sw_w(3'h0, {8'h00, c});
	endtask
	task automatic lw(input hcb_word_t d);
		sw_w(3'h1, d);
	endtask
	task automatic reg_w(input hcb_cmd_t c, input hcb_word_t d);
		lc(c);
		lw(d);
	endtask
	// link read lands in the receive register three cycles on
	task automatic lr(output hcb_word_t d);
		sw_w(3'h2, 16'h0000);
		repeat (3) @(posedge mclk);
		sw_r(3'h3, d);
	endtask
	task automatic chk_w(input string nm, input hcb_word_t e, input hcb_word_t g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_b(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic port_rd(input string nm, input hcb_word_t e);
		hcb_word_t g;
		lr(g);
		chk_w(nm, e, g);
	endtask
	task automatic read_cmp(input hcb_cmd_t c, input string nm, input hcb_word_t e);
		lc(c);
		port_rd(nm, e);
	endtask
	// bounded wait for the active buffer to change, in cycles
	task automatic wait_flip(output int c);
		logic s;
		s = iso_b_act;
		c = 0;
		while (iso_b_act === s && c < 100) begin
			wt(1);
			c++;
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rows = '{'{8'h30, 16'h1234, 16'h1234}, '{8'h47, 16'hFFFF, 16'h000F},
			'{8'h47, 16'h0000, 16'h0000}, '{8'h30, 16'h0040, 16'h0040},
			'{8'h22, 16'hBEEF, 16'hBEEF}, '{8'h25, 16'h0001, 16'h0001},
			'{8'h2C, 16'hFFFF, 16'h003C}};
		fail_count = 0;
		cmp_count  = 0;
		resetn     = 1'b0;
		sw_addr    = 3'h0;
		sw_wdata   = 16'h0000;
		sw_wr      = 1'b0;
		sw_rd      = 1'b0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		read_cmp(8'h30, "size reset", 16'h0000);
		read_cmp(8'h47, "interval reset", 16'h0000);
		read_cmp(8'h32, "setup low reset", 16'h0000);
		port_rd("setup high reset", 16'h0000);
		chk_b("end flag reset", 1'b0, eot_pend);
		$display("test reset done");
		// write then read back each plain register
		foreach (rows[i]) begin
			reg_w(rows[i].cmd | 8'h80, rows[i].wval);
			read_cmp(rows[i].cmd, "table", rows[i].exp);
		end
		$display("test table done");
		// window: reserved bit, four writes into a three-word count
		reg_w(8'hA5, 16'h0001);
		sw_w(3'h5, 16'h0002);
		lc(8'hB2);
		lw(16'h8010);
		lw(16'h0006);
		read_cmp(8'h32, "setup low", 16'h0010);
		port_rd("setup high", 16'h0006);
		lc(8'hC5);
		for (n = 0; n < 4; n++) lw(16'hA000 + 16'(n));
		wt(6);
		chk_b("end flag", 1'b1, eot_pend);
		chk_b("irq", 1'b1, irq);
		sw_r(3'h4, got);
		chk_w("host status", 16'h0007, got);
		wt(2);
		chk_b("irq cleared", 1'b0, irq);
		lc(8'h45);
		for (n = 0; n < 3; n++) port_rd("window", 16'hA000 + 16'(n));
		port_rd("past end", 16'hA002);
		read_cmp(8'h24, "irq status", 16'h0001);
		wt(2);
		chk_b("end flag cleared", 1'b0, eot_pend);
		$display("test window done");
		// iso ports with the device irq masked
		reg_w(8'hA5, 16'h0000);
		reg_w(8'hA2, 16'h0004);
		lc(8'hC0);
		lw(16'hB0B0);
		lw(16'hB1B1);
		wt(4);
		chk_b("iso end flag", 1'b1, eot_pend);
		chk_b("masked irq", 1'b0, link_if.irq);
		reg_w(8'hA2, 16'h0002);
		reg_w(8'hC2, 16'hC0C0);
		lc(8'h2C);
		lr(got);
		chk_w("full bits", 16'h0003, got & 16'h0003);
		lc(8'hB2);
		lw(16'h0000);
		lw(16'h0004);
		read_cmp(8'h45, "a at zero", 16'hB0B0);
		port_rd("a next", 16'hB1B1);
		lc(8'hB2);
		lw(16'h0040);
		lw(16'h0002);
		read_cmp(8'h45, "b at size", 16'hC0C0);
		reg_w(8'hA2, 16'h0002);
		read_cmp(8'h40, "a port", 16'hB0B0);
		reg_w(8'hA2, 16'h0002);
		read_cmp(8'h42, "b port", 16'hC0C0);
		$display("test iso ports done");
		// switch every millisecond, then stop
		reg_w(8'hC7, 16'h0001);
		wait_flip(n);
		wait_flip(n);
		chk_w("switch period", 16'h000A, 16'(n));
		reg_w(8'hC7, 16'h0000);
		wait_flip(n);
		chk_w("no switch", 16'h0064, 16'(n));
		lc(8'h2C);
		lr(got);
		chk_w("done bits", 16'h0300, got & 16'h0303);
		$display("test switch done");
		// second reset in mid-run, with buffer b active so the reset has work to do
		reg_w(8'hC7, 16'h0001);
		wait_flip(n);
		chk_b("active before reset", 1'b1, iso_b_act);
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		read_cmp(8'h30, "size second reset", 16'h0000);
		chk_b("active after reset", 1'b0, iso_b_act);
		$display("test second reset done");
		give_verdict();
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		$display("ERROR watchdog expected finish seen timeout");
		give_verdict();
	end
endmodule
